//--- hdl/pcl_limit_select.v
// current-limit input selection for one pwm generator, with apb registers
`timescale 1ns/1ps
`include "pcl_regs.vh"

// What this block does
// - bits 15 to 13 of the control register are absent and read zero
// - source codes 0 to 3 pick analog comparators one to four
// - source codes 8 to 11 pick shared fault inputs one to four
// - codes 13 and 15 pick independent inputs two and four; others reserved
// - polarity bit zero means active high, one means active low
// - mode bit enables the limit; cleared, the source has no effect
// - during a limit, pin data bits drive high and low pins
module pcl_limit_select (
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] comparatorIn,
    input wire [3:0] sharedFaultIn,
    input wire independentFaultIn2,
    input wire independentFaultIn4,
    input wire pwmHighIn,
    input wire pwmLowIn,
    output reg pwmHighPin,
    output reg pwmLowPin,
    output reg limitActive
);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function [1:0] decodeAddr;
        input [31:0] addr;
        begin
            if (addr[31:`PCL_ADDR_W] != 20'h00000)
                decodeAddr = 2'h3;
            else if (addr[`PCL_ADDR_W-1:0] == `PCL_OFF_CTRL)
                decodeAddr = 2'h0;
            else if (addr[`PCL_ADDR_W-1:0] == `PCL_OFF_IOCTL)
                decodeAddr = 2'h1;
            else if (addr[`PCL_ADDR_W-1:0] == `PCL_OFF_STATUS)
                decodeAddr = 2'h2;
            else
                decodeAddr = 2'h3;
        end
    endfunction

    reg [15:0] controlReg;
    reg [15:0] ioDataReg;
    reg [31:0] readNext;
    reg errNext;
    wire [1:0] regSel;
    wire setupPhase;
    wire rawLevel;
    wire sourceValid;
    wire signalActive;
    wire limitNext;

    assign regSel = decodeAddr(paddr);
    // one wait state: the slave answers in the second access cycle
    assign setupPhase = psel & penable & ~pready;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            controlReg <= `PCL_CTRL_RESET;
            ioDataReg <= `PCL_IOCTL_RESET;
        end else if (setupPhase & pwrite) begin
            if (regSel == 2'h0)
                controlReg <= pwdata[15:0] & `PCL_CTRL_MASK;
            if (regSel == 2'h1)
                ioDataReg <= pwdata[15:0] & `PCL_IOCTL_MASK;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @* begin
        readNext = 32'h00000000;
        errNext = 1'b0;
        case (regSel)
            2'h0: readNext = {16'h0000, controlReg & `PCL_CTRL_MASK};
            2'h1: readNext = {16'h0000, ioDataReg};
            2'h2: begin
                readNext[`PCL_ST_ACTIVE] = limitActive;
                readNext[`PCL_ST_RAW] = rawLevel;
                readNext[`PCL_ST_VALID] = sourceValid;
                readNext[`PCL_ST_HIGH] = pwmHighPin;
                readNext[`PCL_ST_LOW] = pwmLowPin;
            end
            default: errNext = 1'b1;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase & errNext;
            if (setupPhase & ~pwrite)
                prdata <= readNext;
            else if (setupPhase)
                prdata <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // source selection
    // ----------------------------------------
    pcl_source_mux sourceMux (
        .clock(clock),
        .rst(rst),
        .limitSourceSelect(controlReg[`PCL_SRC_HI:`PCL_SRC_LO]),
        .limitPolarity(controlReg[`PCL_POL_BIT]),
        .comparatorIn(comparatorIn),
        .sharedFaultIn(sharedFaultIn),
        .independentFaultIn2(independentFaultIn2),
        .independentFaultIn4(independentFaultIn4),
        .rawLevel(rawLevel),
        .sourceValid(sourceValid),
        .signalActive(signalActive)
    );

    // ----------------------------------------
    // limit condition and pin override
    // ----------------------------------------
    // mode gate sits after the mux so clearing it takes effect one edge after the write
    assign limitNext = controlReg[`PCL_MODE_BIT] & signalActive;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            limitActive <= 1'b0;
            pwmHighPin <= 1'b0;
            pwmLowPin <= 1'b0;
        end else begin
            limitActive <= limitNext;
            if (limitNext) begin
                pwmHighPin <= ioDataReg[`PCL_DAT_HI];
                pwmLowPin <= ioDataReg[`PCL_DAT_LO];
            end else begin
                // no limit (mode cleared or source inactive) leaves generator data untouched
                pwmHighPin <= pwmHighIn;
                pwmLowPin <= pwmLowIn;
            end
        end
    end

endmodule

//--- hdl/pcl_source_mux.v
// registered selection of the current-limit source and its polarity
`timescale 1ns/1ps
`include "pcl_regs.vh"

module pcl_source_mux (
    input wire clock,
    input wire rst,
    input wire [3:0] limitSourceSelect,
    input wire limitPolarity,
    input wire [3:0] comparatorIn,
    input wire [3:0] sharedFaultIn,
    input wire independentFaultIn2,
    input wire independentFaultIn4,
    output reg rawLevel,
    output reg sourceValid,
    output reg signalActive
);

    reg pickLevel;
    reg pickValid;

    // ----------------------------------------
    // source decode
    // ----------------------------------------
    always @* begin
        pickLevel = 1'b0;
        pickValid = 1'b1;
        case (limitSourceSelect)
            `PCL_SRC_CMP1: pickLevel = comparatorIn[0];
            `PCL_SRC_CMP2: pickLevel = comparatorIn[1];
            `PCL_SRC_CMP3: pickLevel = comparatorIn[2];
            `PCL_SRC_CMP4: pickLevel = comparatorIn[3];
            `PCL_SRC_SH1: pickLevel = sharedFaultIn[0];
            `PCL_SRC_SH2: pickLevel = sharedFaultIn[1];
            `PCL_SRC_SH3: pickLevel = sharedFaultIn[2];
            `PCL_SRC_SH4: pickLevel = sharedFaultIn[3];
            `PCL_SRC_IND2: pickLevel = independentFaultIn2;
            `PCL_SRC_IND4: pickLevel = independentFaultIn4;
            default: pickValid = 1'b0; // reserved codes select nothing
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rawLevel <= 1'b0;
            sourceValid <= 1'b0;
            signalActive <= 1'b0;
        end else begin
            rawLevel <= pickLevel;
            sourceValid <= pickValid;
            // polarity one means the source is active low
            signalActive <= pickValid & (pickLevel ^ limitPolarity);
        end
    end

endmodule

//--- shared/pcl_regs.vh
// register map, field positions and codes of the current-limit select block
`ifndef PCL_REGS_VH
`define PCL_REGS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PCL_ADDR_W 12
`define PCL_OFF_CTRL 12'h000
`define PCL_OFF_IOCTL 12'h004
`define PCL_OFF_STATUS 12'h008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PCL_CTRL_MASK 16'h1FFF
`define PCL_CTRL_RESET 16'h0000
`define PCL_SRC_HI 12
`define PCL_SRC_LO 9
`define PCL_POL_BIT 8
`define PCL_MODE_BIT 7

// ----------------------------------------
// pin data register fields
// ----------------------------------------
`define PCL_IOCTL_MASK 16'h000C
`define PCL_IOCTL_RESET 16'h0000
`define PCL_DAT_HI 3
`define PCL_DAT_LO 2

// ----------------------------------------
// status register fields
// ----------------------------------------
`define PCL_ST_ACTIVE 0
`define PCL_ST_RAW 1
`define PCL_ST_VALID 2
`define PCL_ST_HIGH 3
`define PCL_ST_LOW 4

// ----------------------------------------
// source codes
// ----------------------------------------
`define PCL_SRC_CMP1 4'h0
`define PCL_SRC_CMP2 4'h1
`define PCL_SRC_CMP3 4'h2
`define PCL_SRC_CMP4 4'h3
`define PCL_SRC_SH1 4'h8
`define PCL_SRC_SH2 4'h9
`define PCL_SRC_SH3 4'hA
`define PCL_SRC_SH4 4'hB
`define PCL_SRC_IND2 4'hD
`define PCL_SRC_IND4 4'hF

`endif

//--- test/pcl_fault_source_model.sv
// far-side model: comparator and fault input levels
`timescale 1ns/1ps
module pcl_fault_source_model (
    input wire clock,
    input wire freeze,
    output reg [3:0] comparatorIn,
    output reg [3:0] sharedFaultIn,
    output reg independentFaultIn2,
    output reg independentFaultIn4
);
    // levels wander every cycle until frozen, so a read can be predicted
    initial {comparatorIn, sharedFaultIn, independentFaultIn2, independentFaultIn4} = 10'h000;
    always @(posedge clock) begin
        if (!freeze) {comparatorIn, sharedFaultIn, independentFaultIn2, independentFaultIn4} <= 10'($urandom);
    end
endmodule

//--- test/pcl_limit_select_bench.sv
// self-checking bench for the current-limit select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failCount++; $display("BAD %s exp %h got %h", n, e, g); end end
module pcl_limit_select_bench;
    reg clock = 0;
    reg rst = 1;
    reg psel = 0, penable = 0, pwrite = 0, pwmHighIn = 0, pwmLowIn = 0, freeze = 1, err, e;
    reg [31:0] paddr = 0, pwdata = 0, rd;
    reg [7:0] cfg;
    reg [9:0] lv;
    reg [4:0] st;
    wire [31:0] prdata;
    wire pready, pslverr, pwmHighPin, pwmLowPin, limitActive, independentFaultIn2, independentFaultIn4;
    wire [3:0] comparatorIn, sharedFaultIn;
    integer failCount = 0, testsRun = 0, i;
    always #4 clock = ~clock;
    pcl_limit_select i_dut (.*);
    pcl_fault_source_model i_far (.*);
    task apb(input reg w, input reg [31:0] a, input reg [31:0] d);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    function automatic reg expLim(input reg [3:0] s, input reg p, input reg m, input reg [9:0] x);
        reg [15:0] v;
        v = {x[9], 1'b0, x[8], 1'b0, x[7:4], 4'h0, x[3:0]};
        return m && (s < 4'h4 || (s[3] && (s < 4'hC || s[0]))) && (v[s] ^ p);
    endfunction
    task stop_test;
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        failCount++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h43DA674F));
        repeat (4) @(posedge clock);
        rst <= 0;
        apb(0, 32'h4, 0);
        `CHK("pin data reset", 32'h0, rd);
        apb(1, 32'h0, 32'hFFFFFFFF);
        apb(0, 32'h0, 0);
        `CHK("ctrl mask", 32'h00001FFF, rd);
        apb(0, 32'hC, 0);
        `CHK("unmapped", 1'b1, err);
        $display("register test done");
        for (i = 0; i < 64; i++) begin
            cfg = 8'($urandom);
            freeze <= 0;
            apb(1, 32'h4, {28'h0, cfg[1:0], 2'b00});
            apb(1, 32'h0, {19'h0, i[3:0], cfg[3:2], 7'h00});
            {freeze, pwmHighIn, pwmLowIn} <= {1'b1, cfg[5:4]};
            repeat (3) @(posedge clock);
            apb(0, 32'h8, 0);
            lv = {independentFaultIn4, independentFaultIn2, sharedFaultIn, comparatorIn};
            e = expLim(i[3:0], cfg[3], cfg[2], lv);
            // status: low pin, high pin, code valid, raw level, limit
            st = {e ? cfg[0] : cfg[4], e ? cfg[1] : cfg[5],
                expLim(i[3:0], 1'b0, 1'b1, 10'h3FF), expLim(i[3:0], 1'b0, 1'b1, lv), e};
            `CHK("limit", e, rd[0]);
            `CHK("limit out", e, limitActive);
            `CHK("status", st, rd[4:0]);
            `CHK("pins", e ? cfg[1:0] : cfg[5:4], ({pwmHighPin, pwmLowPin}));
        end
        $display("random limit test done");
        stop_test;
    end
endmodule

//--- test/pcl_limit_select_sva.sv
// assertions on the ports of the current-limit select block
`timescale 1ns/1ps
module pcl_limit_select_sva (
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [3:0] comparatorIn,
    input wire [3:0] sharedFaultIn,
    input wire independentFaultIn2,
    input wire independentFaultIn4,
    input wire pwmHighIn,
    input wire pwmLowIn,
    input wire pwmHighPin,
    input wire pwmLowPin,
    input wire limitActive
);
    reg [3:0] srcReg;
    reg polReg;
    reg modeReg;
    reg [1:0] datReg;
    wire wr = psel && penable && !pready && pwrite;
    wire cfgWr = wr && paddr == 32'h0;
    wire [15:0] lvl = {independentFaultIn4, 1'b0, independentFaultIn2, 1'b0, sharedFaultIn, 4'h0, comparatorIn};
    wire ok = srcReg < 4'h4 || (srcReg[3] && (srcReg < 4'hC || srcReg[0]));
    wire expLim = modeReg && ok && (lvl[srcReg] ^ polReg);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // shadow copy of the writable fields, updated on the same edge as the block
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            {srcReg, polReg, modeReg, datReg} <= 8'h00;
        end else begin
            if (cfgWr) {srcReg, polReg, modeReg} <= pwdata[12:7];
            if (wr && paddr == 32'h4) datReg <= pwdata[3:2];
        end
    end
    sequence accessWait;
        psel && penable && !pready;
    endsequence
    sequence modeOff;
        !modeReg [*3];
    endsequence
    a_ready_answer: assert property (accessWait |=> pready) else $error("no ready after access");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_unmapped: assert property (psel && penable && pready |-> pslverr == (paddr > 32'h8 || paddr[1:0] != 2'b00))
        else $error("error flag wrong");
    a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("data on error");
    a_ctrl_top: assert property (pready && !pwrite && paddr == 32'h0 |-> prdata[31:13] == 19'h0)
        else $error("top bits not zero");
    // a config write gets two edges to settle through the mux stage
    a_limit_value: assert property (!$past(cfgWr) && !$past(cfgWr, 2) |-> limitActive == $past(expLim, 2))
        else $error("limit level wrong");
    a_mode_off: assert property (modeOff |-> !limitActive) else $error("limit while disabled");
    a_pin_data: assert property (limitActive |-> {pwmHighPin, pwmLowPin} == $past(datReg))
        else $error("pin data wrong");
    a_pin_follow: assert property (!limitActive |-> pwmHighPin == $past(pwmHighIn) && pwmLowPin == $past(pwmLowIn))
        else $error("pins not following");
endmodule

bind pcl_limit_select pcl_limit_select_sva i_sva (.*);
